// [plic_ctrl.sv]
// Loop lock interrupt, stop-mode clock gating and break flag protection
`timescale 1ns/100ps
module plic_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Loop and system signals from outside this domain
  input wire logic loop_locked,
  input wire logic stop_req,
  input wire logic osc_in_stop_keep,
  input wire logic break_active,
  input wire logic break_clear_enable,
  // Clock generator controls
  output logic osc_enable,
  output logic loop_power_on,
  output logic base_clock_select,
  output logic out_clock_enable,
  // Interrupts
  output logic gen_irq_out,
  output logic irq
);
  logic [1:0] s_lock, s_stop, s_keep, s_brk, s_break_clear_enable;
  logic lock_q, stop_q;
  logic auto_mode, loop_irq_enable, loop_irq_flag;
  logic [plic_pkg::EV_W-1:0] ev_stat, ev_en;
  logic pend;
  logic [31:0] next_readdata;
  logic lock_ev, stop_ev, lock_vis;
  // Power bit as software wrote it, and the loop's actual run state
  logic pon_bit, loop_run;

  // Address match for one register; every write decode goes through here
  function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] ofs);
    return a == ofs;
  endfunction

  // Two-flop synchronisers; only the second stage feeds logic,
  // so a metastable first stage never fans out
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_lock <= 2'h0;
    end else begin
      s_lock <= {s_lock[0], loop_locked};
    end
  end

  // Stop request from the system side
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_stop <= 2'h0;
    end else begin
      s_stop <= {s_stop[0], stop_req};
    end
  end

  // Keep-oscillator configuration level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_keep <= 2'h0;
    end else begin
      s_keep <= {s_keep[0], osc_in_stop_keep};
    end
  end

  // Debug break state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_brk <= 2'h0;
    end else begin
      s_brk <= {s_brk[0], break_active};
    end
  end

  // Break clear enable; sampled with the break level so both age alike
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_break_clear_enable <= 2'h0;
    end else begin
      s_break_clear_enable <= {s_break_clear_enable[0], break_clear_enable};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      lock_q <= s_lock[1];
      stop_q <= s_stop[1];
    end
  end

  assign lock_vis = auto_mode & s_lock[1];
  assign lock_ev = auto_mode & (s_lock[1] ^ lock_q);
  assign stop_ev = s_stop[1] & ~stop_q;
  // Loop runs only when powered and not stopped
  assign loop_run = pon_bit & ~s_stop[1];

  // One wait cycle per access: waitrequest high in the first cycle, request taken on the second edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else begin
      pend <= (read | write) & ~pend;
    end
  end
  assign waitrequest = (read | write) & ~pend;
  logic acc;
  assign acc = (read | write) & pend;
  logic wr_ctrl, wr_bw, wr_clr, wr_ien, clr_allowed;
  // Writes act only at the accepting edge, never in the wait cycle
  assign wr_ctrl = acc & write & reg_hit(address, plic_pkg::OFS_CTRL);
  assign wr_bw = acc & write & reg_hit(address, plic_pkg::OFS_BW);
  assign wr_clr = acc & write & reg_hit(address, plic_pkg::OFS_CLR);
  assign wr_ien = acc & write & reg_hit(address, plic_pkg::OFS_IEN);
  assign clr_allowed = ~s_brk[1] | s_break_clear_enable[1];

  // Bandwidth mode bit, cleared by reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      auto_mode <= plic_pkg::BW_RST[plic_pkg::BW_AUTO];
    end else if (wr_bw) begin
      auto_mode <= writedata[plic_pkg::BW_AUTO];
    end
  end

  // Interrupt enable; wait mode has no input here so it changes nothing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loop_irq_enable <= plic_pkg::CTRL_RST[plic_pkg::CTRL_IE];
    end else if (wr_ctrl) begin
      loop_irq_enable <= writedata[plic_pkg::CTRL_IE];
    end
  end

  // Power bit keeps what software wrote; stop gates the output, not this bit,
  // so the loop comes back on by itself after stop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pon_bit <= plic_pkg::CTRL_RST[plic_pkg::CTRL_PON];
    end else if (wr_ctrl) begin
      pon_bit <= writedata[plic_pkg::CTRL_PON];
    end
  end

  // Stop entry wins over a write in the same cycle; writes during stop
  // are dropped so the crystal source stays selected until stop ends
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      base_clock_select <= plic_pkg::CTRL_RST[plic_pkg::CTRL_BCS];
    end else if (stop_ev) begin
      base_clock_select <= 1'b0;
    end else if (wr_ctrl && !s_stop[1]) begin
      base_clock_select <= writedata[plic_pkg::CTRL_BCS]; // no lock check
    end
  end

  // Flag: set wins over clear; writing 0 clears only outside protected break
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loop_irq_flag <= 1'b0;
    end else if (lock_ev) begin
      loop_irq_flag <= 1'b1;
    end else if (!auto_mode) begin
      loop_irq_flag <= 1'b0;
    end else if (wr_ctrl && !writedata[plic_pkg::CTRL_FLAG] && clr_allowed) begin
      loop_irq_flag <= 1'b0;
    end
  end

  // Sticky event status, write-one-to-clear; set wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ev_stat <= '0;
    end else begin
      for (int i = 0; i < plic_pkg::EV_W; i++) begin
        if ((i == plic_pkg::EV_LOCK && lock_ev) || (i == plic_pkg::EV_STOP && stop_ev)) begin
          ev_stat[i] <= 1'b1;
        end else if (wr_clr && writedata[i]) begin
          ev_stat[i] <= 1'b0;
        end
      end
    end
  end

  // Event enables, same layout as the status bits
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ev_en <= '0;
    end else if (wr_ien) begin
      ev_en <= writedata[plic_pkg::EV_W-1:0];
    end
  end

  // Loop request; held low in stop whatever the flag holds
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gen_irq_out <= 1'b0;
    end else begin
      gen_irq_out <= ~s_stop[1] & auto_mode & loop_irq_flag & loop_irq_enable;
    end
  end

  // Level interrupt for the sticky events
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_stat & ev_en);
    end
  end

  // Oscillator survives stop only when the keep bit is set
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= ~s_stop[1] | s_keep[1];
    end
  end

  // Output clock held low in stop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_clock_enable <= 1'b0;
    end else begin
      out_clock_enable <= ~s_stop[1];
    end
  end

  // Loop power as the loop sees it: off in every kind of stop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loop_power_on <= plic_pkg::CTRL_RST[plic_pkg::CTRL_PON];
    end else begin
      loop_power_on <= loop_run;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_readdata = plic_pkg::BAD_DATA;
    case (address)
      plic_pkg::OFS_CTRL: begin
        next_readdata[plic_pkg::CTRL_IE] = loop_irq_enable;
        next_readdata[plic_pkg::CTRL_FLAG] = auto_mode & loop_irq_flag;
        next_readdata[plic_pkg::CTRL_PON] = pon_bit;
        next_readdata[plic_pkg::CTRL_BCS] = base_clock_select;
        next_readdata[0] = loop_run;
      end
      plic_pkg::OFS_BW: begin
        next_readdata[plic_pkg::BW_AUTO] = auto_mode;
        next_readdata[plic_pkg::BW_LOCK] = lock_vis;
      end
      plic_pkg::OFS_STAT: next_readdata[plic_pkg::EV_W-1:0] = ev_stat;
      plic_pkg::OFS_IEN: next_readdata[plic_pkg::EV_W-1:0] = ev_en;
      default: next_readdata = plic_pkg::BAD_DATA;
    endcase
  end

  // Read data loaded in the wait cycle, so it stands at the accepting edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readdata <= plic_pkg::BAD_DATA;
    end else if (read & ~pend) begin
      readdata <= next_readdata;
    end
  end

  // Every access answers OK; unmapped writes are simply dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      response <= 2'h0;
    end else begin
      response <= 2'h0;
    end
  end
endmodule

// [plic_pkg.sv]
// Constants for the loop lock interrupt and low-power clock control block
// How it works
// - In automatic bandwidth mode every toggle of the lock indicator sets the loop interrupt flag.
// - The interrupt request goes out only while the loop interrupt enable bit is set.
// - The flag sets on a lock change whatever the enable bit holds.
// - With automatic mode off the request is suppressed and the flag reads as zero.
// - The loop-derived source may be selected even while unlocked; no lock check is made.
// - Wait mode leaves the clock generator state unchanged.
// - Stop with the keep-oscillator bit clear turns off oscillator and loop and holds the output clock and loop request low.
// - Stop entered with the loop clock selected clears the base clock select bit.
// - After stop the crystal source drives the output clock and the select bit reads clear.
// - Stop with the keep-oscillator bit set turns off the loop but keeps the oscillator running.
// - With break clear enable at one, a flag cleared during break stays cleared afterwards.
// - With break clear enable at zero, control register writes during break leave the loop interrupt flag alone.
// - The lock indicator is read-only, follows loop lock in automatic mode, and reads zero otherwise.
// - Reset clears automatic mode, so the loop starts manual with its interrupt path off.
package plic_pkg;
  // Word offsets (byte addresses) on the register bus
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_BW = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_CLR = 5'h0c;
  localparam logic [4:0] OFS_IEN = 5'h10;
  // Control register fields
  localparam int CTRL_IE = 7;
  localparam int CTRL_FLAG = 6;
  localparam int CTRL_PON = 5;
  localparam int CTRL_BCS = 4;
  // Bandwidth register fields
  localparam int BW_AUTO = 7;
  localparam int BW_LOCK = 6;
  // Event status bits
  localparam int EV_LOCK = 0;
  localparam int EV_STOP = 1;
  localparam int EV_W = 2;
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam logic [7:0] BW_RST = 8'h00;
  localparam logic [31:0] BAD_DATA = 32'h0000_0000;
endpackage

// [plic_ctrl_asserts.sv]
// Port-level checks for the loop control block
`timescale 1ns/100ps
module plic_ctrl_asserts (
  // Clock, reset and bus
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  // Loop and clock controls
  input wire logic loop_locked,
  input wire logic stop_req,
  input wire logic osc_in_stop_keep,
  input wire logic osc_enable,
  input wire logic loop_power_on,
  input wire logic base_clock_select,
  input wire logic out_clock_enable,
  input wire logic gen_irq_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic ie;
  logic au;
  wire acc_w = write && !waitrequest;
  // Shadow of the enable and auto bits, taken at the accepting edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ie <= 1'b0;
      au <= 1'b0;
    end else begin
      if (acc_w && address == 4'h0) ie <= writedata[7];
      if (acc_w && address == 4'h4) au <= writedata[7];
    end
  end
  chk_wait_first: assert property ($rose(read) |-> waitrequest) else $error("no wait cycle");
  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
  chk_stop_low: assert property ((stop_req && !osc_in_stop_keep) [*4] |->
    !osc_enable && !loop_power_on && !out_clock_enable && !gen_irq_out) else $error("outputs live in stop");
  chk_stop_keep: assert property ((stop_req && osc_in_stop_keep) [*4] |->
    osc_enable && !loop_power_on) else $error("oscillator not kept");
  chk_stop_bcs: assert property (stop_req [*4] |-> !base_clock_select) else $error("select kept in stop");
  chk_irq_gate: assert property (!ie && !$past(ie) |-> !gen_irq_out) else $error("request while disabled");
  chk_lock_irq: assert property (au && ie && !stop_req && $changed(loop_locked) |->
    ##[3:6] gen_irq_out) else $error("no request on lock change");
  chk_bcs_write: assert property (acc_w && address == 4'h0 && writedata[4] && !stop_req |->
    ##[1:2] base_clock_select) else $error("select refused");
endmodule

// [plic_loop_model.sv]
// Behavioural loop that locks some cycles after power-on
`timescale 1ns/100ps
module plic_loop_model #(parameter int LOCK_CYC = 5) (
  // Controls
  input wire logic mclk,
  input wire logic loop_power_on,
  input wire logic lock_cmd,
  // Lock indicator
  output logic loop_locked
);
  int cnt = 0;
  // An unpowered loop can never report lock
  always @(posedge mclk) begin
    cnt <= (loop_power_on && lock_cmd) ? cnt + 1 : 0;
    loop_locked <= loop_power_on && lock_cmd && cnt >= LOCK_CYC;
  end
endmodule

// [plic_ctrl_test.sv]
// Self-checking bench for the loop control block
`timescale 1ns/100ps
module plic_ctrl_test;
  logic mclk = 0, rst_n = 0, read = 0, write = 0, lock_cmd = 0, stop_req = 0, osc_in_stop_keep = 0;
  logic break_active = 0, break_clear_enable = 0, waitrequest, loop_locked, osc_enable, loop_power_on;
  logic base_clock_select, out_clock_enable, gen_irq_out, irq;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, rdat;
  logic [1:0] response;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZRO = 32'h0000_0000;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #10 mclk = ~mclk;
  plic_ctrl plic_ctrl_i (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .response(response),
    .loop_locked(loop_locked), .stop_req(stop_req), .osc_in_stop_keep(osc_in_stop_keep),
    .break_active(break_active), .break_clear_enable(break_clear_enable), .osc_enable(osc_enable),
    .loop_power_on(loop_power_on), .base_clock_select(base_clock_select),
    .out_clock_enable(out_clock_enable), .gen_irq_out(gen_irq_out), .irq(irq));
  plic_loop_model plic_loop_model_i (.mclk(mclk), .loop_power_on(loop_power_on), .lock_cmd(lock_cmd),
    .loop_locked(loop_locked));
  function automatic logic [31:0] b(input logic s);
    return {31'h0, s};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    // Look mid-cycle, then act at the rising edge where it is low
    @(negedge mclk);
    while (waitrequest !== 1'b0) begin
      @(negedge mclk);
    end
    @(posedge mclk);
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(a, 1'b0, ZRO);
    chk(rdat & m, e);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well above the roughly 150 cycles the sequence needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0000_00F0, 32'h0000_0020);
    rd(4'h4, 32'h0000_00C0, ZRO);
    lock_cmd <= 1'b1;
    repeat (14) @(posedge mclk);
    rd(4'h4, 32'h0000_00C0, ZRO);
    rd(4'h0, 32'h0000_0040, ZRO);
    lock_cmd <= 1'b0;
    wr(4'h4, 32'h0000_0080);
    lock_cmd <= 1'b1;
    repeat (14) @(posedge mclk);
    rd(4'h4, 32'h0000_00C0, 32'h0000_00C0);
    rd(4'h0, 32'h0000_00F0, 32'h0000_0060);
    chk(b(gen_irq_out), ZRO);
    wr(4'h0, 32'h0000_0070);
    rd(4'h0, 32'h0000_0010, 32'h0000_0010);
    wr(4'h0, 32'h0000_00E0);
    break_active <= 1'b1;
    repeat (4) @(negedge mclk);
    chk(b(gen_irq_out), ONE);
    wr(4'h0, 32'h0000_00A0);
    rd(4'h0, 32'h0000_00F0, 32'h0000_00E0);
    break_clear_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(4'h0, 32'h0000_00A0);
    break_active <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(4'h0, 32'h0000_00F0, 32'h0000_00A0);
    break_clear_enable <= 1'b0;
    lock_cmd <= 1'b0;
    repeat (8) @(negedge mclk);
    chk(b(gen_irq_out), ONE);
    rd(4'h4, 32'h0000_00C0, 32'h0000_0080);
    rd(plic_pkg::OFS_STAT, 32'h0000_0001, ONE);
    wr(plic_pkg::OFS_IEN, ONE);
    repeat (2) @(negedge mclk);
    chk(b(irq), ONE);
    wr(plic_pkg::OFS_IEN, ZRO);
    repeat (2) @(negedge mclk);
    chk(b(irq), ZRO);
    chk({30'h0, response}, ZRO);
    wr(plic_pkg::OFS_IEN, ONE);
    wr(plic_pkg::OFS_CLR, ONE);
    rd(plic_pkg::OFS_STAT, 32'h0000_0001, ZRO);
    chk(b(irq), ZRO);
    rd(4'h6, 32'hFFFF_FFFF, ZRO);
    wr(4'h0, 32'h0000_0030);
    rd(4'h0, 32'h0000_00F0, 32'h0000_0030);
    wr(4'h4, ZRO);
    stop_req <= 1'b1;
    repeat (6) @(negedge mclk);
    chk(b(osc_enable | loop_power_on | out_clock_enable), ZRO);
    chk(b(base_clock_select), ZRO);
    @(posedge mclk);
    stop_req <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(4'h0, 32'h0000_0010, ZRO);
    osc_in_stop_keep <= 1'b1;
    stop_req <= 1'b1;
    repeat (6) @(negedge mclk);
    chk({30'h0, osc_enable, loop_power_on}, 32'h0000_0002);
    end_sim();
  end
endmodule
bind plic_ctrl plic_ctrl_asserts plic_ctrl_asserts_i (.mclk(mclk), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest), .loop_locked(loop_locked),
  .stop_req(stop_req), .osc_in_stop_keep(osc_in_stop_keep), .osc_enable(osc_enable),
  .loop_power_on(loop_power_on), .base_clock_select(base_clock_select),
  .out_clock_enable(out_clock_enable), .gen_irq_out(gen_irq_out));
